// ### design/stim_cfg_pkg.sv
package stim_cfg_pkg;
   localparam logic [7:0] RATIO_ADDR = 8'h44;
   localparam logic [7:0] TIMING_ADDR = 8'h45;
   localparam logic [7:0] RESP_ADDR = 8'h46;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam int RATIO_LSB = 0;
   localparam int COND_LSB = 0;
   localparam int DELAY_LSB = 3;
   localparam int TYPE_BIT = 6;
   localparam int RESP_LSB = 0;
   localparam int MAG_LSB = 4;
   localparam logic [2:0] RATIO_RESERVED = 3'h7;
   localparam logic [3:0] MAG_RESERVED = 4'hf;
   localparam int CLK_KHZ = 20000;
   // Delay table in milliseconds, indexed by the delay code.
   localparam int DELAY_MS [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
   typedef enum logic [2:0] {
      ACT_NONE = 3'h0, ACT_VOLT = 3'h1, ACT_RES = 3'h2, ACT_DIV = 3'h3, ACT_BRIDGE = 3'h4
   } action_t;
endpackage : stim_cfg_pkg

// ### design/custom_charger_stimulus_config.sv
`timescale 1ns/10ps
module custom_charger_stimulus_config #(
   parameter int CLK_KHZ = stim_cfg_pkg::CLK_KHZ // Clock rate in kHz.
) (
   input wire logic clk, // 20 MHz clock.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic wrEn, // Register write strobe.
   input wire logic [7:0] addr, // Register address.
   input wire logic [7:0] wrData, // Write data.
   output logic [7:0] rdData, // Read data for addr.
   input wire logic bc12Active, // BC1.2 profile active.
   input wire logic [3:0] stage1_response_select, // Stage 1 response code.
   output logic [2:0] stage1_divider_ratio, // Ratio code in force.
   output logic ratioApply, // Divider ratio in use.
   output logic stage2_timer_behavior, // Timer behaviour bit.
   output logic [2:0] stage2_delay_select, // Delay code.
   output logic [2:0] stage2_condition_select, // Trigger condition.
   output logic [3:0] stage2_response_select, // Response code.
   output logic [3:0] stage2_response_magnitude, // Magnitude code.
   output stim_cfg_pkg::action_t responseAction, // Decoded response kind.
   output logic [23:0] stimulus_delay_time // Delay in clock cycles.
);
   logic [2:0] ratio_reg, ratio_next;
   logic [6:0] timing_reg, timing_next;
   logic [7:0] resp_reg, resp_next;
   logic [2:0] wCond;
   logic [3:0] wResp, wMag;

   // Field validation and register update; reserved encodings keep the old value.
   always_comb begin
      ratio_next = ratio_reg;
      timing_next = timing_reg;
      resp_next = resp_reg;
      wCond = wrData[stim_cfg_pkg::COND_LSB +: 3];
      wResp = wrData[stim_cfg_pkg::RESP_LSB +: 4];
      wMag = wrData[stim_cfg_pkg::MAG_LSB +: 4];
      // Ratio is frozen while BC1.2 runs so a legacy setting is not disturbed.
      if (wrEn && addr == stim_cfg_pkg::RATIO_ADDR && !bc12Active &&
          wrData[2:0] != stim_cfg_pkg::RATIO_RESERVED) begin
         ratio_next = wrData[2:0];
      end
      if (wrEn && addr == stim_cfg_pkg::TIMING_ADDR) begin
         timing_next[6:3] = wrData[6:3];
         if (wCond != 3'h4 && wCond != 3'h5) begin
            timing_next[2:0] = wCond;
         end
      end
      if (wrEn && addr == stim_cfg_pkg::RESP_ADDR) begin
         if (wResp != 4'h5 && wResp != 4'h8 && wResp != 4'hb) begin
            resp_next[3:0] = wResp;
         end
         if (wMag != stim_cfg_pkg::MAG_RESERVED) begin
            resp_next[7:4] = wMag;
         end
      end
   end

   // Registers; all fields clear at power-on.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ratio_reg <= stim_cfg_pkg::RESET_VALUE[2:0];
         timing_reg <= stim_cfg_pkg::RESET_VALUE[6:0];
         resp_reg <= stim_cfg_pkg::RESET_VALUE;
      end else begin
         ratio_reg <= ratio_next;
         timing_reg <= timing_next;
         resp_reg <= resp_next;
      end
   end

   // Readback; unimplemented and unmapped bits read as zero.
   always_comb begin
      case (addr)
         stim_cfg_pkg::RATIO_ADDR: rdData = {5'h00, ratio_reg};
         stim_cfg_pkg::TIMING_ADDR: rdData = {1'b0, timing_reg};
         stim_cfg_pkg::RESP_ADDR: rdData = resp_reg;
         default: rdData = 8'h00;
      endcase
   end

   assign stage1_divider_ratio = ratio_reg;
   // Only divider responses of a legacy profile use the ratio.
   assign ratioApply = !bc12Active && (stage1_response_select == 4'h6 ||
      stage1_response_select == 4'h9 || stage1_response_select == 4'hc);
   assign stage2_timer_behavior = timing_reg[stim_cfg_pkg::TYPE_BIT];
   assign stage2_delay_select = timing_reg[stim_cfg_pkg::DELAY_LSB +: 3];
   assign stage2_condition_select = timing_reg[stim_cfg_pkg::COND_LSB +: 3];
   assign stage2_response_select = resp_reg[3:0];
   // Magnitude meaning follows the kind of response selected.
   assign stage2_response_magnitude = resp_reg[7:4];
   assign stimulus_delay_time =
      24'(stim_cfg_pkg::DELAY_MS[stage2_delay_select] * CLK_KHZ);

   // Response kind decode.
   always_comb begin
      case (resp_reg[3:0])
         4'h1, 4'h2, 4'h3: responseAction = stim_cfg_pkg::ACT_VOLT;
         4'h4, 4'h7, 4'hd: responseAction = stim_cfg_pkg::ACT_RES;
         4'h6, 4'h9, 4'hc: responseAction = stim_cfg_pkg::ACT_DIV;
         4'ha: responseAction = stim_cfg_pkg::ACT_BRIDGE;
         default: responseAction = stim_cfg_pkg::ACT_NONE;
      endcase
   end

   // Register checks; all of them rest while reset is low, as every field is cleared then.
   property p_reserved_ratio;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::RATIO_ADDR && wrData[2:0] == 3'h7)
         |=> $stable(stage1_divider_ratio);
   endproperty
   a_reserved_ratio: assert property (p_reserved_ratio)
      else $error("Reserved ratio taken.");
   property p_bc12_freeze;
      @(posedge clk) disable iff (!resetn) bc12Active |=> $stable(stage1_divider_ratio);
   endproperty
   a_bc12_freeze: assert property (p_bc12_freeze)
      else $error("Ratio changed under BC1.2.");
   property p_ratio_write;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::RATIO_ADDR && !bc12Active && wrData[2:0] != 3'h7)
         |=> stage1_divider_ratio == $past(wrData[2:0]);
   endproperty
   a_ratio_write: assert property (p_ratio_write) else $error("Ratio write lost.");
   property p_ratio_apply;
      @(posedge clk) disable iff (!resetn)
      ratioApply |-> (stage1_response_select inside {4'h6, 4'h9, 4'hc});
   endproperty
   a_ratio_apply: assert property (p_ratio_apply) else $error("Ratio applied wrongly.");
   property p_upper_zero;
      @(posedge clk) disable iff (!resetn)
      (addr == stim_cfg_pkg::RATIO_ADDR |-> rdData[7:3] == 5'h00) and
      (addr == stim_cfg_pkg::TIMING_ADDR |-> !rdData[7]);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("Upper bits not zero.");
   property p_cond_reserved;
      @(posedge clk) disable iff (!resetn)
      !(stage2_condition_select inside {3'h4, 3'h5});
   endproperty
   a_cond_reserved: assert property (p_cond_reserved)
      else $error("Reserved condition held.");
   property p_resp_reserved;
      @(posedge clk) disable iff (!resetn)
      !(stage2_response_select inside {4'h5, 4'h8, 4'hb}) && stage2_response_magnitude != 4'hf;
   endproperty
   a_resp_reserved: assert property (p_resp_reserved)
      else $error("Reserved response held.");
   property p_delay_max;
      @(posedge clk) disable iff (!resetn)
      stage2_delay_select == 3'h7 |-> stimulus_delay_time == 24'(100 * CLK_KHZ);
   endproperty
   a_delay_max: assert property (p_delay_max) else $error("Delay count wrong.");
   property p_div_kind;
      @(posedge clk) disable iff (!resetn)
      stage2_response_select == 4'hc |-> responseAction == stim_cfg_pkg::ACT_DIV;
   endproperty
   a_div_kind: assert property (p_div_kind) else $error("Divider decode wrong.");
   // A legacy profile with a divider response must see the ratio in use.
   property p_apply_divider;
      @(posedge clk) disable iff (!resetn)
      (!bc12Active && stage1_response_select inside {4'h6, 4'h9, 4'hc}) |-> ratioApply;
   endproperty
   a_apply_divider: assert property (p_apply_divider)
      else $error("Divider ratio not applied.");
   // The ratio must stay unused while a BC1.2 profile runs.
   property p_bc12_unused;
      @(posedge clk) disable iff (!resetn)
      bc12Active |-> !ratioApply;
   endproperty
   a_bc12_unused: assert property (p_bc12_unused)
      else $error("Ratio used under BC1.2.");
   // Delay code and timer bit are taken on every write to the timing register.
   property p_timing_write;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::TIMING_ADDR) |=>
         (stage2_delay_select == $past(wrData[5:3]) &&
          stage2_timer_behavior == $past(wrData[6]));
   endproperty
   a_timing_write: assert property (p_timing_write)
      else $error("Delay or timer write lost.");
   // An accepted condition code lands one cycle after the write.
   property p_cond_write;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::TIMING_ADDR && !(wrData[2:0] inside {3'h4, 3'h5}))
         |=> stage2_condition_select == $past(wrData[2:0]);
   endproperty
   a_cond_write: assert property (p_cond_write)
      else $error("Condition write lost.");
   // A reserved condition code leaves the old trigger in force.
   property p_cond_keep;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::TIMING_ADDR && wrData[2:0] inside {3'h4, 3'h5})
         |=> $stable(stage2_condition_select);
   endproperty
   a_cond_keep: assert property (p_cond_keep)
      else $error("Reserved condition taken.");
   // A reserved response code leaves the old response in force.
   property p_resp_keep;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::RESP_ADDR && wrData[3:0] inside {4'h5, 4'h8, 4'hb})
         |=> $stable(stage2_response_select);
   endproperty
   a_resp_keep: assert property (p_resp_keep)
      else $error("Reserved response taken.");
   // An accepted response code lands one cycle after the write.
   property p_resp_write;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::RESP_ADDR && !(wrData[3:0] inside {4'h5, 4'h8, 4'hb}))
         |=> stage2_response_select == $past(wrData[3:0]);
   endproperty
   a_resp_write: assert property (p_resp_write)
      else $error("Response write lost.");
   // The reserved magnitude is refused on its own, whatever the response field holds.
   property p_mag_keep;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::RESP_ADDR && wrData[7:4] == 4'hf)
         |=> $stable(stage2_response_magnitude);
   endproperty
   a_mag_keep: assert property (p_mag_keep)
      else $error("Reserved magnitude taken.");
   // Any other magnitude lands one cycle after the write.
   property p_mag_write;
      @(posedge clk) disable iff (!resetn)
      (wrEn && addr == stim_cfg_pkg::RESP_ADDR && wrData[7:4] != 4'hf)
         |=> stage2_response_magnitude == $past(wrData[7:4]);
   endproperty
   a_mag_write: assert property (p_mag_write)
      else $error("Magnitude write lost.");
   // Response codes one to three read the magnitude as a voltage.
   property p_volt_kind;
      @(posedge clk) disable iff (!resetn)
      stage2_response_select inside {4'h1, 4'h2, 4'h3} |-> responseAction == stim_cfg_pkg::ACT_VOLT;
   endproperty
   a_volt_kind: assert property (p_volt_kind)
      else $error("Voltage decode wrong.");
   // Delay code zero means no wait at all.
   property p_delay_zero;
      @(posedge clk) disable iff (!resetn)
      stage2_delay_select == 3'h0 |-> stimulus_delay_time == 24'h000000;
   endproperty
   a_delay_zero: assert property (p_delay_zero)
      else $error("Zero delay not zero.");
endmodule : custom_charger_stimulus_config

// ### bench/device_side_model.sv
`timescale 1ns/10ps
// Stands in for the attached device: its stage 1 response code moves on the falling edge.
module device_side_model (
   input wire logic clk, // Bench clock.
   input wire logic [3:0] wantCode, // Code the scenario asks for.
   output logic [3:0] respCode // Code seen by the block.
);
   // Starts at zero so the block never sees an unknown code; one process drives the code.
   initial begin
      respCode = 4'h0;
      forever begin
         @(negedge clk);
         respCode <= wantCode;
      end
   end
endmodule : device_side_model

// ### bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin nMismatch++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
   localparam int KHZ = 20000;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wrEn = 1'b0;
   logic bc12Active = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wrData = 8'h00;
   logic [7:0] rdData;
   logic [3:0] wantCode = 4'h0;
   logic [3:0] s1Code, resp, mag;
   logic [2:0] ratio, delaySel, cond;
   logic apply, timerType;
   logic [23:0] delayTime;
   stim_cfg_pkg::action_t act;
   int nMismatch = 0;
   int checked = 0;
   int cyc = 0;
   int ms [8] = '{0, 1, 5, 10, 20, 40, 80, 100};
   device_side_model peer (.clk(clk), .wantCode(wantCode), .respCode(s1Code));
   custom_charger_stimulus_config #(.CLK_KHZ(KHZ)) dut (.clk(clk), .resetn(resetn),
      .wrEn(wrEn), .addr(addr), .wrData(wrData), .rdData(rdData), .bc12Active(bc12Active),
      .stage1_response_select(s1Code), .stage1_divider_ratio(ratio), .ratioApply(apply),
      .stage2_timer_behavior(timerType), .stage2_delay_select(delaySel),
      .stage2_condition_select(cond), .stage2_response_select(resp),
      .stage2_response_magnitude(mag), .responseAction(act), .stimulus_delay_time(delayTime));
   // Half period of 25 ns gives the 20 MHz clock.
   always #25 clk = ~clk;
   task report_and_stop;
      if (nMismatch == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // A hang costs one mismatch; the whole run needs under two hundred cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         nMismatch++;
         report_and_stop;
      end
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {wrEn, addr, wrData} = {1'b1, a, d};
      @(negedge clk);
      wrEn = 1'b0;
   endtask : wr
   // Address moves on a falling edge; read data is combinational and settles just after.
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      #1;
      `CHK("rdData", e, rdData)
   endtask : rd
   task t_ratio;
      for (int i = 0; i < 7; i++) begin
         wr(8'h44, {5'h1f, i[2:0]});
         rd(8'h44, {5'h00, i[2:0]});
         `CHK("ratio", i[2:0], ratio)
      end
      wr(8'h44, 8'h07);
      rd(8'h44, 8'h06);
      `CHK("ratio", 3'h6, ratio)
      @(negedge clk);
      bc12Active = 1'b1;
      wr(8'h44, 8'h02);
      rd(8'h44, 8'h06);
      @(negedge clk);
      bc12Active = 1'b0;
   endtask : t_ratio
   task t_apply(input logic bc);
      @(negedge clk);
      bc12Active = bc;
      for (int i = 0; i < 16; i++) begin
         wantCode = i[3:0];
         repeat (2) @(negedge clk);
         `CHK("ratioApply", !bc && (i inside {6, 9, 12}), apply)
      end
   endtask : t_apply
   task t_timing;
      for (int i = 0; i < 8; i++) begin
         wr(8'h45, {2'b11, i[2:0], 3'h6});
         rd(8'h45, {2'b01, i[2:0], 3'h6});
         `CHK("delay", 24'(ms[i] * KHZ), delayTime)
         `CHK("delaySel", i[2:0], delaySel)
         `CHK("timer", 1'b1, timerType)
      end
      wr(8'h45, 8'h04);
      rd(8'h45, 8'h06);
      `CHK("timer", 1'b0, timerType)
      `CHK("cond", 3'h6, cond)
      wr(8'h45, 8'h07);
      wr(8'h45, 8'h2d);
      rd(8'h45, 8'h2f);
      `CHK("cond", 3'h7, cond)
   endtask : t_timing
   task t_resp;
      logic [3:0] e;
      e = 4'h0;
      for (int i = 0; i < 16; i++) begin
         wr(8'h46, {4'h2, i[3:0]});
         if (!(i inside {5, 8, 11})) e = i[3:0];
         `CHK("resp", e, resp)
         `CHK("mag", 4'h2, mag)
         `CHK("act", stim_cfg_pkg::action_t'(e inside {1, 2, 3} ? 1 : e inside {4, 7, 13} ? 2 :
            e inside {6, 9, 12} ? 3 : e == 10 ? 4 : 0), act)
      end
      wr(8'h46, 8'hf1);
      rd(8'h46, 8'h21);
      `CHK("mag", 4'h2, mag)
   endtask : t_resp
   // A reset in mid-run clears the ratio, condition and magnitude fields; a write on the first edge after release lands.
   task t_reset;
      @(negedge clk);
      resetn = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("ratio", 3'h0, ratio)
      `CHK("cond", 3'h0, cond)
      `CHK("mag", 4'h0, mag)
      resetn = 1'b1;
      {wrEn, addr, wrData} = {1'b1, 8'h46, 8'ha3};
      @(negedge clk);
      wrEn = 1'b0;
      `CHK("resp", 4'h3, resp)
      `CHK("mag", 4'ha, mag)
      `CHK("act", stim_cfg_pkg::ACT_VOLT, act)
      `CHK("rdData", 8'ha3, rdData)
   endtask : t_reset
   // Reset is held for 20 cycles, then the scenarios run in turn.
   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      rd(8'h45, 8'h00);
      `CHK("act", stim_cfg_pkg::ACT_NONE, act)
      t_ratio;
      t_apply(1'b0);
      t_apply(1'b1);
      t_timing;
      t_resp;
      t_reset;
      rd(8'h47, 8'h00);
      report_and_stop;
   end
endmodule : tb_top
